// [include/kbs_pkg.sv]
// Purpose: Shared constants and types for the keyboard matrix scanner
// Assumes: 250 MHz system clock
// Notes: Times are kept in ns, cycle counts derived from them
package kbs_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int BASE_PERIOD_NS = 3000;
   localparam int BASE_HALF_NS = BASE_PERIOD_NS / 2;
   localparam int BASE_HALF_CYC = BASE_HALF_NS / CLK_PERIOD_NS;
   localparam int KEY_MIN_NS = 1500;
   localparam int KEY_MIN_CYC_RAW = (KEY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int KEY_MIN_CYC = (KEY_MIN_CYC_RAW < 1) ? 1 : KEY_MIN_CYC_RAW;
   localparam int DIV_W = 10;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BASE_HALF_CYC - 1);
   localparam logic [DIV_W-1:0] KEY_LAST = DIV_W'(KEY_MIN_CYC - 1);
   localparam logic [DIV_W-1:0] DIV_RST = 10'h000;

   // Matrix geometry
   localparam int CNT_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [3:0] FUNC_COL = 4'h3;
   localparam logic [15:0] COL_IDLE = 16'hFFFF;

   // Register map, byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_KEYDATA = 4'h8;
   localparam logic [3:0] REG_LOADS = 4'hC;
   localparam logic CTRL_RST = 1'b1;
   localparam int CTRL_EN_BIT = 0;
   localparam int ST_KEY_BIT = 0;
   localparam int ST_KEYM1_BIT = 1;
   localparam int ST_PKDM1_BIT = 2;
   localparam int ST_THR_BIT = 3;
   localparam int ST_CNT_LSB = 8;
   localparam logic [15:0] LOADS_RST = 16'h0000;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Two-phase clock bundle
   typedef struct packed {
      logic base;
      logic six;
      logic phi1_n;
      logic phi2_n;
   } kbs_phase_s;

   // Host strobe sequencer
   typedef enum logic [1:0] {
      STRB_IDLE,
      STRB_ARM,
      STRB_LOW
   } kbs_strb_e;
endpackage : kbs_pkg

// [hdl/kbs_phase_gen.sv]
// Purpose: Base oscillator, divide-by-two and two-phase clock enables
// Assumes: Runs from the single system clock
// Notes: All phases are flip-flop levels, sampled by the scanner
`timescale 1ns/10ps
`default_nettype none
module kbs_phase_gen
   import kbs_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic run,
   output kbs_phase_s phase
);
   logic [DIV_W-1:0] div_q, div_d;
   logic base_q, base_d;
   logic six_q, six_d;
   logic phi1_n_q, phi1_n_d;
   logic phi2_n_q, phi2_n_d;

   // Square wave of 3 us period, halted while scanning is off
   always_comb begin
      div_d = div_q;
      base_d = base_q;
      six_d = six_q;
      if (run) begin
         if (div_q == DIV_LAST) begin
            div_d = DIV_RST;
            base_d = ~base_q;
            if (base_q) begin
               six_d = ~six_q;
            end
         end else begin
            div_d = div_q + 10'h001;
         end
      end
      phi1_n_d = ~(base_d & six_d);
      phi2_n_d = ~(base_d & ~six_d);
   end

   // Register phase state
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_q <= DIV_RST;
         base_q <= 1'b0;
         six_q <= 1'b0;
         phi1_n_q <= 1'b1;
         phi2_n_q <= 1'b1;
      end else begin
         div_q <= div_d;
         base_q <= base_d;
         six_q <= six_d;
         phi1_n_q <= phi1_n_d;
         phi2_n_q <= phi2_n_d;
      end
   end

   // Bundle out
   assign phase = '{base: base_q, six: six_q, phi1_n: phi1_n_q, phi2_n: phi2_n_q};
endmodule : kbs_phase_gen
`default_nettype wire

// [hdl/kbs_scanner.sv]
// Purpose: Keyboard matrix scan timing and key-closure qualification
// Assumes: Detector output and repeat input synchronous to clock
// Notes: Registers on Avalon-MM, one wait state per access
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module kbs_scanner
   import kbs_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic key_det_n,
   input wire logic repeat_active,
   input wire logic [3:0] enc_hi,
   output logic [15:0] column_n,
   output logic [2:0] row_sel,
   output logic [1:0] row_bank_en,
   output logic prior_detect_threshold_n,
   output logic [3:0] enc_col,
   output logic [7:0] kbd_data,
   output logic kbd_strobe_n
);
   kbs_phase_s ph;
   logic ctrl_en_q, ctrl_en_d;

   // Phase generator
   kbs_phase_gen u_phase (
      .clock(clock),
      .nrst(nrst),
      .run(ctrl_en_q),
      .phase(ph)
   );

   // Matrix address helpers
   function automatic logic [3:0] col_of(input logic [CNT_W-1:0] c);
      col_of = c[7:4];
   endfunction : col_of

   function automatic logic [15:0] col_decode(input logic [CNT_W-1:0] c, input logic en);
      col_decode = COL_IDLE;
      if (en) begin
         col_decode[col_of(c)] = 1'b0;
      end
   endfunction : col_decode

   // Phase history for edge detection
   logic p1_q, p2_q, six_q;
   logic phi1_fall, phi1_rise, phi2_rise, six_fall;
   assign phi1_fall = p1_q & ~ph.phi1_n;
   assign phi1_rise = ~p1_q & ph.phi1_n;
   assign phi2_rise = ~p2_q & ph.phi2_n;
   assign six_fall = six_q & ~ph.six;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         p1_q <= 1'b1;
         p2_q <= 1'b1;
         six_q <= 1'b0;
      end else begin
         p1_q <= ph.phi1_n;
         p2_q <= ph.phi2_n;
         six_q <= ph.six;
      end
   end

   // Scan counter and matrix drive
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [15:0] col_q, col_d;
   logic [2:0] row_q, row_d;
   logic [1:0] bank_q, bank_d;

   always_comb begin
      cnt_d = cnt_q;
      if (phi1_fall) begin
         cnt_d = cnt_q + 8'h01;
      end
      col_d = col_decode(cnt_d, ph.phi1_n);
      row_d = cnt_d[2:0];
      bank_d = {cnt_d[3], ~cnt_d[3]};
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_q <= CNT_RST;
         col_q <= COL_IDLE;
         row_q <= 3'h0;
         bank_q <= 2'h1;
      end else begin
         cnt_q <= cnt_d;
         col_q <= col_d;
         row_q <= row_d;
         bank_q <= bank_d;
      end
   end

   // Key-present flag with pulse-width filter
   logic key_q, key_d;
   logic [DIV_W-1:0] filt_q, filt_d;

   always_comb begin
      key_d = key_q;
      filt_d = filt_q;
      if (!ph.phi1_n) begin
         key_d = 1'b0;
         filt_d = DIV_RST;
      end else if (!key_det_n) begin
         if (filt_q == KEY_LAST) begin
            key_d = 1'b1;
         end else begin
            filt_d = filt_q + 10'h001;
         end
      end else begin
         filt_d = DIV_RST;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         key_q <= 1'b0;
         filt_q <= DIV_RST;
      end else begin
         key_q <= key_d;
         filt_q <= filt_d;
      end
   end

   // Status memory, two bits per row-column address
   logic [1:0] mem [MEM_DEPTH];
   logic [MEM_DEPTH-1:0] valid_q, valid_d;
   logic [1:0] rd_bits;
   logic mem_we;
   logic [1:0] mem_wdata;
   logic key_m1_q, key_m1_d;
   logic pkd_m1_q, pkd_m1_d;
   logic thr_n_q, thr_n_d;

   assign rd_bits = valid_q[cnt_q] ? mem[cnt_q] : 2'b00;

   always_comb begin
      key_m1_d = key_m1_q;
      pkd_m1_d = pkd_m1_q;
      thr_n_d = thr_n_q;
      valid_d = valid_q;
      mem_we = 1'b0;
      mem_wdata = {key_q & (key_m1_q | pkd_m1_q), key_q};
      if (phi1_rise) begin
         key_m1_d = rd_bits[0];
         pkd_m1_d = rd_bits[1];
         thr_n_d = ~rd_bits[1];
      end
      if (phi2_rise) begin
         mem_we = 1'b1;
         valid_d[cnt_q] = 1'b1;
         thr_n_d = ~mem_wdata[1];
      end
   end

   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[cnt_q] <= mem_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         valid_q <= '0;
         key_m1_q <= 1'b0;
         pkd_m1_q <= 1'b0;
         thr_n_q <= 1'b1;
      end else begin
         valid_q <= valid_d;
         key_m1_q <= key_m1_d;
         pkd_m1_q <= pkd_m1_d;
         thr_n_q <= thr_n_d;
      end
   end

   // Output-latch strobe and data latch
   logic cond, cond_q, load;
   logic [7:0] data_q, data_d;
   logic [15:0] loads_q, loads_d;

   assign cond = key_q & key_m1_q & ~ph.phi2_n & ~repeat_active
      & ~pkd_m1_q & (col_of(cnt_q) != FUNC_COL);
   assign load = cond & ~cond_q;

   always_comb begin
      data_d = data_q;
      loads_d = loads_q;
      if (load) begin
         data_d = {enc_hi, cnt_q[3:0]};
         loads_d = loads_q + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cond_q <= 1'b0;
         data_q <= DATA_RST;
         loads_q <= LOADS_RST;
      end else begin
         cond_q <= cond;
         data_q <= data_d;
         loads_q <= loads_d;
      end
   end

   // Host strobe, aligned to the inverted 6 us clock
   kbs_strb_e strb_q, strb_d;
   logic strobe_n_q, strobe_n_d;

   always_comb begin
      strb_d = strb_q;
      case (strb_q)
         STRB_IDLE: begin
            if (load) begin
               strb_d = STRB_ARM;
            end
         end
         STRB_ARM: begin
            if (six_fall) begin
               strb_d = STRB_LOW;
            end
         end
         STRB_LOW: begin
            if (six_fall) begin
               strb_d = load ? STRB_ARM : STRB_IDLE;
            end
         end
         default: begin
            strb_d = STRB_IDLE;
         end
      endcase
      strobe_n_d = (strb_d != STRB_LOW);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         strb_q <= STRB_IDLE;
         strobe_n_q <= 1'b1;
      end else begin
         strb_q <= strb_d;
         strobe_n_q <= strobe_n_d;
      end
   end

   // Avalon-MM slave, answers on the second edge of a request
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] status_w;

   always_comb begin
      status_w = RDATA_RST;
      status_w[ST_KEY_BIT] = key_q;
      status_w[ST_KEYM1_BIT] = key_m1_q;
      status_w[ST_PKDM1_BIT] = pkd_m1_q;
      status_w[ST_THR_BIT] = ~thr_n_q;
      status_w[ST_CNT_LSB +: CNT_W] = cnt_q;
   end

   always_comb begin
      ack_d = (avs_read | avs_write) & ~ack_q;
      rdata_d = rdata_q;
      ctrl_en_d = ctrl_en_q;
      if (ack_d & avs_read) begin
         case (avs_address)
            REG_CTRL: rdata_d = {31'h0000_0000, ctrl_en_q};
            REG_STATUS: rdata_d = status_w;
            REG_KEYDATA: rdata_d = {24'h00_0000, data_q};
            REG_LOADS: rdata_d = {16'h0000, loads_q};
            default: rdata_d = RDATA_RST;
         endcase
      end
      // Write lands on the edge where waitrequest is seen low
      if (ack_q & avs_write & (avs_address == REG_CTRL) & avs_byteenable[0]) begin
         ctrl_en_d = avs_writedata[CTRL_EN_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         rdata_q <= RDATA_RST;
         ctrl_en_q <= CTRL_RST;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ctrl_en_q <= ctrl_en_d;
      end
   end

   // Outputs
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata = rdata_q;
   assign column_n = col_q;
   assign row_sel = row_q;
   assign row_bank_en = bank_q;
   assign prior_detect_threshold_n = thr_n_q;
   assign enc_col = col_of(cnt_q);
   assign kbd_data = data_q;
   assign kbd_strobe_n = strobe_n_q;
endmodule : kbs_scanner
`default_nettype wire

// [verification/kbs_scanner_assertions.sv]
// Purpose: Port-level timing checks for the keyboard scanner
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every kbs_scanner instance
`timescale 1ns/10ps
`default_nettype none
module kbs_scanner_chk
   import kbs_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] enc_hi,
   input wire logic [15:0] column_n,
   input wire logic [2:0] row_sel,
   input wire logic [1:0] row_bank_en,
   input wire logic prior_detect_threshold_n,
   input wire logic [3:0] enc_col,
   input wire logic [7:0] kbd_data,
   input wire logic kbd_strobe_n
);
   logic [10:0] low_q;
   logic [10:0] low_d;
   logic [7:0] kd_q;
   logic [10:0] gap_q;
   logic [10:0] gap_d;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Length of the current host strobe pulse
   always_comb begin
      low_d = kbd_strobe_n ? 11'h000 : low_q + 11'h001;
      // Cycles from a latch load until the strobe goes low
      gap_d = 11'h000;
      if (kbd_strobe_n && (kbd_data != kd_q || gap_q != 11'h000)) begin
         gap_d = gap_q + 11'h001;
      end
   end
   always_ff @(posedge clock) begin
      low_q <= nrst ? low_d : 11'h000;
      kd_q <= kbd_data;
      gap_q <= nrst ? gap_d : 11'h000;
   end
   // Column and row scan shape
   property p_one_col; $onehot0(~column_n); endproperty
   a_one_col: assert property (p_one_col) else $error("two columns low");
   property p_col_dec; column_n != COL_IDLE |-> column_n == ~(16'h0001 << enc_col); endproperty
   a_col_dec: assert property (p_col_dec) else $error("wrong column low");
   property p_bank; row_bank_en[1] != row_bank_en[0]; endproperty
   a_bank: assert property (p_bank) else $error("row banks not exclusive");
   property p_row_first; $changed(enc_col) |-> $past(row_sel, 2) == 3'h7 && $past(row_bank_en, 2) == 2'b10; endproperty
   a_row_first: assert property (p_row_first) else $error("column moved before last row");
   property p_idle; $changed(row_sel) |-> ##2 (column_n == COL_IDLE) [*8]; endproperty
   a_idle: assert property (p_idle) else $error("column driven while count moves");
   // Output latch and host strobe
   property p_str_len; $rose(kbd_strobe_n) |-> low_q == 11'h5DC; endproperty
   a_str_len: assert property (p_str_len) else $error("strobe length wrong");
   property p_str_start; gap_q <= 11'h640; endproperty
   a_str_start: assert property (p_str_start) else $error("no strobe after load");
   property p_data; $changed(kbd_data) |-> kbd_data == {$past(enc_hi), row_bank_en[1], row_sel}; endproperty
   a_data: assert property (p_data) else $error("latch content wrong");
   property p_no_func; $changed(kbd_data) |-> enc_col != FUNC_COL; endproperty
   a_no_func: assert property (p_no_func) else $error("load on function column");
   c_strobe: cover property ($fell(kbd_strobe_n));
   c_load: cover property ($changed(kbd_data));
   c_thr: cover property ($fell(prior_detect_threshold_n));
endmodule : kbs_scanner_chk
bind kbs_scanner kbs_scanner_chk u_kbs_scanner_chk (.clock, .nrst, .enc_hi, .column_n, .row_sel,
   .row_bank_en, .prior_detect_threshold_n, .enc_col, .kbd_data, .kbd_strobe_n);
`default_nettype wire

// [verification/kbs_keymat.sv]
// Purpose: Capacitive key matrix and detector facing the scanner
// Assumes: keys holds one bit per column-row address
// Notes: Detector rests high while no column is driven
`timescale 1ns/10ps
`default_nettype none
module kbs_keymat (
   input wire logic [15:0] column_n,
   input wire logic [2:0] row_sel,
   input wire logic [1:0] row_bank_en,
   input wire logic [255:0] keys,
   output logic key_det_n
);
   // A held key under the driven column and selected row pulls the detector low
   always_comb begin
      key_det_n = 1'b1;
      for (int c = 0; c < 16; c++) begin
         if (!column_n[c] && row_bank_en != 2'b00 && keys[{c[3:0], row_bank_en[1], row_sel}]) begin
            key_det_n = 1'b0;
         end
      end
   end
endmodule : kbs_keymat
`default_nettype wire

// [verification/tb_kbs_scanner.sv]
// Purpose: Self-checking bench for the keyboard matrix scanner
// Assumes: Full scans of 256 counts at 1500 cycles each
// Notes: Long run, scan timing has no shortening parameter
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_kbs_scanner;
   import kbs_pkg::*;
   logic clock, nrst, rd, wr, rep, det_n, wreq, strb_n, thr_n;
   logic [3:0] addr, hi, col;
   logic [31:0] wdat, rdat, q, s;
   logic [15:0] col_n;
   logic [2:0] row;
   logic [1:0] bank;
   logic [7:0] kd;
   logic [255:0] keys;
   int errors, checks, n;
   logic thr_d1;
   int thr_falls = 0;
   kbs_scanner u_kbs_scanner (.clock(clock), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .key_det_n(det_n), .repeat_active(rep), .enc_hi(hi), .column_n(col_n), .row_sel(row),
      .row_bank_en(bank), .prior_detect_threshold_n(thr_n), .enc_col(col), .kbd_data(kd), .kbd_strobe_n(strb_n));
   kbs_keymat u_kbs_keymat (.column_n(col_n), .row_sel(row), .row_bank_en(bank), .keys(keys), .key_det_n(det_n));
   // Counts each lowering of the detect threshold
   always @(posedge clock) begin
      thr_d1 <= thr_n;
      if (nrst && thr_d1 && !thr_n) thr_falls <= thr_falls + 1;
   end
   // Free-running 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Counts and verdict
   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   // One Avalon-MM access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      rd <= !w;
      wr <= w;
      addr <= a;
      wdat <= d;
      do begin
         @(posedge clock);
         k++;
      end while (wreq !== 1'b0 && k < 100);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 100) begin
         errors++;
         results();
      end
      @(posedge clock);
   endtask : bus
   // Bounded wait for the host strobe to reach a level
   task automatic until_strb(input logic lvl, input int lim);
      n = 0;
      while (strb_n !== lvl && n < lim) begin
         @(negedge clock);
         n++;
      end
      if (n >= lim) begin
         errors++;
         results();
      end
   endtask : until_strb
   // Main sequence
   initial begin
      nrst = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      rep = 1'b0;
      hi = 4'hA;
      addr = 4'h0;
      wdat = 32'h0000_0000;
      keys = '0;
      keys[8'h05] = 1'b1;
      keys[8'h07] = 1'b1;
      keys[8'h32] = 1'b1;
      errors = 0;
      checks = 0;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      bus(1'b0, REG_CTRL, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0001, q)
      bus(1'b1, REG_KEYDATA, 32'h0000_00FF);
      bus(1'b0, REG_KEYDATA, 32'h0000_0000);
      `CHK("keydata", 32'h0000_0000, q)
      bus(1'b0, REG_LOADS, 32'h0000_0000);
      `CHK("loads", 32'h0000_0000, q)
      bus(1'b0, 4'h2, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, q)
      bus(1'b1, REG_CTRL, 32'h0000_0000);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      s = q;
      repeat (3000) @(posedge clock);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      `CHK("frozen count", s[15:8], q[15:8])
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      $display("test registers done");
      until_strb(1'b0, 800000);
      `CHK("second scan", 1'b1, n > 300000)
      `CHK("latch", 8'hA5, kd)
      @(posedge clock);
      rep <= 1'b1;
      until_strb(1'b1, 2000);
      `CHK("strobe width", 1500, n)
      repeat (4500) @(posedge clock);
      rep <= 1'b0;
      $display("test first load done");
      repeat (400000) @(posedge clock);
      bus(1'b0, REG_LOADS, 32'h0000_0000);
      `CHK("loads", 32'h0000_0001, q)
      `CHK("latch kept", 8'hA5, kd)
      `CHK("threshold falls", 5, thr_falls)
      $display("test blocked loads done");
      results();
   end
endmodule : tb_kbs_scanner
`default_nettype wire
